// file: rtl/cam_pkg.sv
// Constants for the capture, accumulator and modulus down-counter unit.
// Assumes an 8-bit register port with one-cycle strobes and a 200 MHz module clock.
package cam_pkg;
  localparam logic [7:0] ADDR_ACC3 = 8'hA2;
  localparam logic [7:0] ADDR_ACC2 = 8'hA3;
  localparam logic [7:0] ADDR_MC_CTL = 8'hA6;
  localparam logic [7:0] ADDR_MC_FLG = 8'hA7;
  localparam logic [7:0] ADDR_ACC_EN = 8'hA8;
  localparam logic [7:0] ADDR_DLY = 8'hA9;
  localparam logic [7:0] ADDR_NOVW = 8'hAA;
  localparam logic [7:0] ADDR_SYS = 8'hAB;
  localparam logic [7:0] ADDR_ACC_HOLD = 8'hAC;
  localparam logic [7:0] ADDR_ACC1 = 8'hB2;
  localparam logic [7:0] ADDR_ACC0 = 8'hB3;
  localparam logic [7:0] ADDR_MC_HI = 8'hB6;
  localparam logic [7:0] ADDR_MC_LO = 8'hB7;
  localparam logic [7:0] ADDR_CAP_HOLD = 8'hB8;
  localparam logic [7:0] ADDR_CAP = 8'h90;

  localparam int unsigned CTL_IRQ_EN = 7;
  localparam int unsigned CTL_RELOAD = 6;
  localparam int unsigned CTL_RDSEL = 5;
  localparam int unsigned CTL_FLATCH = 4;
  localparam int unsigned CTL_FLOAD = 3;
  localparam int unsigned CTL_EN = 2;
  localparam int unsigned FLG_UFLOW = 7;
  localparam int unsigned SYS_SHARE_LO = 4;
  localparam int unsigned SYS_FLAG_SETTING_MODE = 3;
  localparam int unsigned SYS_SAT = 2;
  localparam int unsigned SYS_BUF = 1;
  localparam int unsigned SYS_LATCH_OR_QUEUE = 0;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_FULL = 8'hFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] COUNT_IDLE = 16'hFFFF;

  localparam logic [10:0] DELAY_SHORT = 11'h100;
  localparam logic [10:0] DELAY_MID = 11'h200;
  localparam logic [10:0] DELAY_LONG = 11'h400;
  localparam logic [3:0] PRESC_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_DIV4 = 4'h3;
  localparam logic [3:0] PRESC_DIV8 = 4'h7;
  localparam logic [3:0] PRESC_DIV16 = 4'hF;

  typedef enum logic {FILT_IDLE, FILT_WAIT} filt_state_t;
endpackage

// file: rtl/capture_accumulator_modulus_unit.sv
// Capture buffering, byte pulse accumulators and the modulus down-counter.
// Assumes pins and strobes synchronous to core_clk and a main timer value from outside.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module capture_accumulator_modulus_unit
  import cam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] capture_pin,
  input wire logic [3:0] edge_rise_en,
  input wire logic [3:0] edge_fall_en,
  input wire logic [15:0] timer_count,
  input wire logic first_cascade_enable,
  input wire logic second_cascade_enable,
  input wire logic first_cascade_event,
  input wire logic fast_flag_clear,
  input wire logic normal_mode_indicator,
  output logic [3:0] capture_flags,
  output logic [3:0] channel_share,
  output logic first_overflow_flag,
  output logic second_overflow_flag,
  output logic underflow_irq
);

  function automatic logic [10:0] delay_last(input logic [1:0] sel);
    case (sel)
      2'b01: delay_last = DELAY_SHORT - 11'h001;
      2'b10: delay_last = DELAY_MID - 11'h001;
      default: delay_last = DELAY_LONG - 11'h001;
    endcase
  endfunction

  function automatic logic [3:0] presc_last(input logic [1:0] sel);
    case (sel)
      2'b00: presc_last = PRESC_DIV1;
      2'b01: presc_last = PRESC_DIV4;
      2'b10: presc_last = PRESC_DIV8;
      default: presc_last = PRESC_DIV16;
    endcase
  endfunction

  function automatic logic [7:0] bump_byte(input logic [7:0] v, input logic sat);
    if (sat && v == BYTE_FULL) begin
      bump_byte = v;
    end else begin
      bump_byte = 8'(v + 8'h01);
    end
  endfunction

  logic [1:0] dly_sel_q;
  logic [7:0] novw_q;
  logic [7:0] sys_q;
  logic sys_written_q;
  logic [3:0] acc_en_q;
  logic [7:0] acc_q [4];
  logic [7:0] acc_d [4];
  logic irq_en_q, reload_q, rdsel_q, mc_en_q;
  logic [1:0] presc_sel_q;
  logic underflow_flag_q;
  logic [15:0] cnt_q, load_q;
  logic [3:0] presc_q;
  logic [1:0] rate_q;
  logic [7:0] wr_hi_buf_q, rd_lo_buf_q;
  logic [15:0] cap_q [4];
  logic [15:0] hold_q [4];
  logic [7:0] acc_hold_q [4];
  logic [3:0] cap_full_q, hold_full_q;
  logic [3:0] polf_q, pol_arm_q;
  filt_state_t fstate_q [4];
  logic [10:0] fcnt_q [4];
  logic [3:0] fpre_q, pin_prev_q;
  logic [3:0] edge_raw, ev, ev_pol;
  logic [3:0] rd_cap, rd_hold, move, latch_move, capture;
  logic ovf_a, ovf_b;
  logic [7:0] rd_val;

  wire logic buffered = sys_q[SYS_BUF];
  wire logic latch_mode = buffered & sys_q[SYS_LATCH_OR_QUEUE];
  wire logic queue_mode = buffered & ~sys_q[SYS_LATCH_OR_QUEUE];
  wire logic [15:0] mc_wval = {wr_hi_buf_q, reg_wdata};
  wire logic wr_mc_lo = reg_wr && reg_addr == ADDR_MC_LO;
  wire logic wr_ctl = reg_wr && reg_addr == ADDR_MC_CTL;
  wire logic force_load = wr_ctl && reg_wdata[CTL_FLOAD] && mc_en_q;
  wire logic force_latch = wr_ctl && reg_wdata[CTL_FLATCH];
  wire logic zero_write = wr_mc_lo && mc_wval == WORD_ZERO;
  wire logic tick = presc_q == presc_last(rate_q);
  wire logic reach_zero = mc_en_q && tick && cnt_q == WORD_ONE && !wr_mc_lo && !force_load;
  wire logic latch_ev = latch_mode && (force_latch || reach_zero || zero_write);
  wire logic mc_access = (reg_rd || reg_wr) && (reg_addr == ADDR_MC_HI || reg_addr == ADDR_MC_LO);
  wire logic underflow_flag_clr = (reg_wr && reg_addr == ADDR_MC_FLG && reg_wdata[FLG_UFLOW])
                        || (fast_flag_clear && mc_access);

  // Edge detection and the optional delay filter in front of each channel.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      edge_raw[n] = (capture_pin[n] & ~pin_prev_q[n] & edge_rise_en[n])
                    | (~capture_pin[n] & pin_prev_q[n] & edge_fall_en[n]);
      if (dly_sel_q == 2'b00) begin
        ev[n] = edge_raw[n];
        ev_pol[n] = capture_pin[n];
      end else begin
        ev[n] = fstate_q[n] == FILT_WAIT && fcnt_q[n] == delay_last(dly_sel_q)
                && capture_pin[n] != fpre_q[n];
        ev_pol[n] = ~fpre_q[n];
      end
    end
  end

  // Edges arriving while a delay is running are ignored, so narrow glitches are dropped.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_prev_q <= 4'h0;
      fpre_q <= 4'h0;
      for (int n = 0; n < 4; n++) begin
        fstate_q[n] <= FILT_IDLE;
        fcnt_q[n] <= 11'h000;
      end
    end else begin
      pin_prev_q <= capture_pin;
      for (int n = 0; n < 4; n++) begin
        if (dly_sel_q == 2'b00) begin
          fstate_q[n] <= FILT_IDLE;
          fcnt_q[n] <= 11'h000;
        end else begin
          case (fstate_q[n])
            FILT_IDLE: begin
              if (edge_raw[n]) begin
                fstate_q[n] <= FILT_WAIT;
                fcnt_q[n] <= 11'h000;
                fpre_q[n] <= pin_prev_q[n];
              end
            end
            FILT_WAIT: begin
              if (fcnt_q[n] == delay_last(dly_sel_q)) begin
                fstate_q[n] <= FILT_IDLE;
                fcnt_q[n] <= 11'h000;
              end else begin
                fcnt_q[n] <= 11'(fcnt_q[n] + 11'h001);
              end
            end
            default: fstate_q[n] <= FILT_IDLE;
          endcase
        end
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dly_sel_q <= 2'b00;
      novw_q <= BYTE_RESET;
      sys_q <= BYTE_RESET;
      sys_written_q <= 1'b0;
      acc_en_q <= 4'h0;
      irq_en_q <= 1'b0;
      reload_q <= 1'b0;
      rdsel_q <= 1'b0;
      mc_en_q <= 1'b0;
      presc_sel_q <= 2'b00;
      wr_hi_buf_q <= BYTE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_DLY: dly_sel_q <= reg_wdata[1:0];
        ADDR_NOVW: novw_q <= reg_wdata;
        ADDR_ACC_EN: acc_en_q <= reg_wdata[3:0];
        ADDR_MC_HI: wr_hi_buf_q <= reg_wdata;
        ADDR_SYS: begin
          if (!normal_mode_indicator || !sys_written_q) begin
            sys_q <= reg_wdata;
            sys_written_q <= 1'b1;
          end
        end
        ADDR_MC_CTL: begin
          irq_en_q <= reg_wdata[CTL_IRQ_EN];
          reload_q <= reg_wdata[CTL_RELOAD];
          rdsel_q <= reg_wdata[CTL_RDSEL];
          mc_en_q <= reg_wdata[CTL_EN];
          presc_sel_q <= reg_wdata[1:0];
        end
        default: ;
      endcase
    end
  end

  // Modulus down-counter. The reload happens on the tick that would reach zero.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= COUNT_IDLE;
      load_q <= WORD_ZERO;
      presc_q <= 4'h0;
      rate_q <= 2'b00;
    end else begin
      if (wr_mc_lo) begin
        load_q <= mc_wval;
      end
      if (!mc_en_q) begin
        cnt_q <= COUNT_IDLE;
        presc_q <= 4'h0;
        rate_q <= presc_sel_q;
      end else if (wr_mc_lo && (!reload_q || zero_write)) begin
        cnt_q <= mc_wval;
        presc_q <= 4'h0;
        rate_q <= presc_sel_q;
      end else if (force_load) begin
        cnt_q <= load_q;
        presc_q <= 4'h0;
        rate_q <= reg_wdata[1:0];
      end else if (cnt_q != WORD_ZERO) begin
        if (tick) begin
          presc_q <= 4'h0;
          if (cnt_q == WORD_ONE && reload_q) begin
            cnt_q <= load_q;
            rate_q <= presc_sel_q;
          end else begin
            cnt_q <= 16'(cnt_q - WORD_ONE);
          end
        end else begin
          presc_q <= 4'(presc_q + 4'h1);
        end
      end
    end
  end

  // A new underflow in the same cycle as a clear keeps the flag set.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      underflow_flag_q <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      underflow_flag_q <= reach_zero | (underflow_flag_q & ~underflow_flag_clr);
      underflow_irq <= underflow_flag_q & irq_en_q;
    end
  end

  // Accumulator next values; bus writes and latch clears take priority over counting.
  always_comb begin
    ovf_a = 1'b0;
    ovf_b = 1'b0;
    for (int n = 0; n < 4; n++) begin
      acc_d[n] = acc_q[n];
    end
    for (int p = 0; p < 2; p++) begin
      logic casc;
      logic cev;
      logic [15:0] pair;
      logic ovf;
      casc = (p == 1) ? first_cascade_enable : second_cascade_enable;
      cev = (p == 1) ? first_cascade_event : ev[0];
      pair = {acc_q[2 * p + 1], acc_q[2 * p]};
      ovf = 1'b0;
      if (casc) begin
        if (cev) begin
          pair = 16'(pair + WORD_ONE);
          ovf = acc_q[2 * p + 1] == BYTE_FULL && acc_q[2 * p] == BYTE_FULL;
          acc_d[2 * p + 1] = pair[15:8];
          acc_d[2 * p] = pair[7:0];
        end
      end else begin
        for (int b = 0; b < 2; b++) begin
          if (acc_en_q[2 * p + b] && ev[2 * p + b]) begin
            acc_d[2 * p + b] = bump_byte(acc_q[2 * p + b], sys_q[SYS_SAT]);
          end
        end
        ovf = acc_en_q[2 * p + 1] && ev[2 * p + 1] && !sys_q[SYS_SAT]
              && acc_q[2 * p + 1] == BYTE_FULL;
      end
      if (p == 1) begin
        ovf_a = ovf;
      end else begin
        ovf_b = ovf;
      end
    end
    if (latch_ev) begin
      for (int n = 0; n < 4; n++) begin
        acc_d[n] = BYTE_RESET;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_ACC3: acc_d[3] = reg_wdata;
        ADDR_ACC2: acc_d[2] = reg_wdata;
        ADDR_ACC1: acc_d[1] = reg_wdata;
        ADDR_ACC0: acc_d[0] = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int n = 0; n < 4; n++) begin
        acc_q[n] <= BYTE_RESET;
      end
      first_overflow_flag <= 1'b0;
      second_overflow_flag <= 1'b0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        acc_q[n] <= acc_d[n];
      end
      first_overflow_flag <= ovf_a;
      second_overflow_flag <= ovf_b;
    end
  end

  // Capture and holding decisions for each channel.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      rd_cap[n] = reg_rd && reg_addr[7:3] == ADDR_CAP[7:3] && reg_addr[2:1] == 2'(n);
      rd_hold[n] = reg_rd && reg_addr[7:3] == ADDR_CAP_HOLD[7:3] && reg_addr[2:1] == 2'(n);
      move[n] = queue_mode && ev[n] && (cap_full_q[n] || !novw_q[n])
                && (!novw_q[n] || !hold_full_q[n]);
      latch_move[n] = latch_ev && (!novw_q[n] || !hold_full_q[n]);
      capture[n] = ev[n] && (!novw_q[n] || !cap_full_q[n] || move[n] || latch_move[n]);
    end
  end

  // Status set by an event wins over the clear made by a read in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cap_full_q <= 4'h0;
      hold_full_q <= 4'h0;
      polf_q <= 4'h0;
      pol_arm_q <= 4'hF;
      capture_flags <= 4'h0;
      channel_share <= 4'h0;
      for (int n = 0; n < 4; n++) begin
        cap_q[n] <= WORD_ZERO;
        hold_q[n] <= WORD_ZERO;
        acc_hold_q[n] <= BYTE_RESET;
      end
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (latch_move[n]) begin
          hold_q[n] <= cap_q[n];
          acc_hold_q[n] <= acc_q[n];
        end else if (move[n]) begin
          hold_q[n] <= cap_q[n];
        end
        if (capture[n]) begin
          cap_q[n] <= timer_count;
        end
        cap_full_q[n] <= capture[n] | (cap_full_q[n] & ~rd_cap[n] & ~latch_move[n]);
        hold_full_q[n] <= latch_move[n] | move[n] | (hold_full_q[n] & ~rd_hold[n]);
        if (capture[n] && pol_arm_q[n]) begin
          polf_q[n] <= ev_pol[n];
        end
        pol_arm_q[n] <= rd_cap[n] | (pol_arm_q[n] & ~capture[n]);
        capture_flags[n] <= (queue_mode && sys_q[SYS_FLAG_SETTING_MODE]) ? move[n] : ev[n];
        channel_share[n] <= ev[n] & sys_q[SYS_SHARE_LO + n];
      end
    end
  end

  // Read multiplexer. Read the counter high byte first; it snapshots the low byte of the counter, or of the load register when rdsel_q is set.
  always_comb begin
    rd_val = BYTE_RESET;
    case (reg_addr)
      ADDR_DLY: rd_val = {6'h00, dly_sel_q};
      ADDR_NOVW: rd_val = novw_q;
      ADDR_SYS: rd_val = sys_q;
      ADDR_ACC_EN: rd_val = {4'h0, acc_en_q};
      ADDR_ACC3: rd_val = acc_q[3];
      ADDR_ACC2: rd_val = acc_q[2];
      ADDR_ACC1: rd_val = acc_q[1];
      ADDR_ACC0: rd_val = acc_q[0];
      ADDR_MC_CTL: rd_val = {irq_en_q, reload_q, rdsel_q, 2'b00, mc_en_q, presc_sel_q};
      ADDR_MC_FLG: rd_val = {underflow_flag_q, 3'b000, polf_q};
      ADDR_MC_HI: rd_val = rdsel_q ? load_q[15:8] : cnt_q[15:8];
      ADDR_MC_LO: rd_val = rd_lo_buf_q;
      default: begin
        if (reg_addr[7:3] == ADDR_CAP[7:3]) begin
          rd_val = reg_addr[0] ? cap_q[reg_addr[2:1]][7:0] : cap_q[reg_addr[2:1]][15:8];
        end else if (reg_addr[7:3] == ADDR_CAP_HOLD[7:3]) begin
          rd_val = reg_addr[0] ? hold_q[reg_addr[2:1]][7:0] : hold_q[reg_addr[2:1]][15:8];
        end else if (reg_addr[7:2] == ADDR_ACC_HOLD[7:2]) begin
          rd_val = acc_hold_q[reg_addr[1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= BYTE_RESET;
      rd_lo_buf_q <= BYTE_RESET;
    end else begin
      reg_rdata <= reg_rd ? rd_val : BYTE_RESET;
      if (reg_rd && reg_addr == ADDR_MC_HI) begin
        rd_lo_buf_q <= rdsel_q ? load_q[7:0] : cnt_q[7:0];
      end
    end
  end

endmodule

// file: dv/cam_checker_properties.sv
// Port-level assertions for the capture, accumulator and down-counter unit.
// Assumes it is bound to the unit and sees every register access from reset on.
`timescale 1ns/10ps
module cam_checker
  import cam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] capture_pin,
  input wire logic [3:0] edge_rise_en,
  input wire logic [3:0] edge_fall_en,
  input wire logic [15:0] timer_count,
  input wire logic first_cascade_enable,
  input wire logic second_cascade_enable,
  input wire logic first_cascade_event,
  input wire logic fast_flag_clear,
  input wire logic normal_mode_indicator,
  input wire logic [3:0] capture_flags,
  input wire logic [3:0] channel_share,
  input wire logic first_overflow_flag,
  input wire logic second_overflow_flag,
  input wire logic underflow_irq
);
  logic [7:0] ctl_q;
  logic [7:0] sys_q;
  logic [1:0] dly_q;
  logic sys_done_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctl_q <= 8'h00;
      sys_q <= 8'h00;
      dly_q <= 2'h0;
      sys_done_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MC_CTL) begin
        ctl_q <= reg_wdata;
      end
      if (reg_addr == ADDR_DLY) begin
        dly_q <= reg_wdata[1:0];
      end
      // A refused second setup must not leak into the shadow, or every later read would differ.
      if (reg_addr == ADDR_SYS && !(normal_mode_indicator && sys_done_q)) begin
        sys_q <= reg_wdata;
        sys_done_q <= 1'b1;
      end
    end
  end

  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data not idle.");
  ctl_read_a: assert property (reg_rd && reg_addr == ADDR_MC_CTL |=> reg_rdata == (ctl_q & 8'hE7))
    else $error("Control read wrong.");
  sys_once_a: assert property (reg_rd && reg_addr == ADDR_SYS |=> reg_rdata == sys_q)
    else $error("System control read wrong.");
  dly_read_a: assert property (reg_rd && reg_addr == ADDR_DLY |=> reg_rdata == {6'h00, dly_q})
    else $error("Delay select read wrong.");
  idle_count_a: assert property (reg_rd && reg_addr == ADDR_MC_HI && !ctl_q[CTL_RDSEL]
    && !ctl_q[CTL_EN] && !$past(ctl_q[CTL_EN]) && !$past(ctl_q[CTL_EN], 2) |=> reg_rdata == 8'hFF)
    else $error("Disabled count not FFFF.");
  irq_gate_a: assert property (underflow_irq |-> $past(ctl_q[CTL_IRQ_EN]))
    else $error("Interrupt without enable.");
  irq_drop_a: assert property (reg_wr && reg_addr == ADDR_MC_CTL && !reg_wdata[CTL_IRQ_EN]
    |-> ##2 !underflow_irq)
    else $error("Interrupt stayed after disable.");
  share_gate_a: assert property ((channel_share & ~sys_q[7:4] & ~$past(sys_q[7:4])) == 4'h0)
    else $error("Share pulse without share bit.");
  ovf_pulse_a: assert property (first_overflow_flag |=> !first_overflow_flag)
    else $error("Overflow pulse too long.");
  ovf_cause_a: assert property (first_overflow_flag && first_cascade_enable
    |-> $past(first_cascade_event) || $past(first_cascade_event, 2))
    else $error("Overflow without count event.");
  bypass_cap_a: assert property (capture_flags[0] && dly_q == 2'h0 && $past(dly_q) == 2'h0
    |-> $past(capture_pin[0]) != $past(capture_pin[0], 2))
    else $error("Capture flag without edge.");

  cover property (underflow_irq);
  cover property (first_overflow_flag);
  cover property (channel_share[0]);
endmodule

// file: dv/pin_source.sv
// Far-side model of the timer pins: capture inputs and the first cascade count line.
// Assumes one bench process calls its tasks; levels change just after a rising edge.
`timescale 1ns/10ps
module pin_source (
  input wire logic core_clk,
  output logic [3:0] capture_pin,
  output logic cascade_event
);
  initial begin
    capture_pin = 4'h0;
    cascade_event = 1'b0;
  end

  task automatic set_pin(input int ch, input logic lvl);
    @(posedge core_clk);
    capture_pin[ch] <= lvl;
  endtask

  // A gap follows each pulse, since a real synchroniser loses pulses closer than two clocks.
  task automatic count_pulse();
    @(posedge core_clk);
    cascade_event <= 1'b1;
    @(posedge core_clk);
    cascade_event <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the capture, accumulator and modulus down-counter unit.
// Assumes the pin model drives the capture inputs and the bench owns the register port.
`timescale 1ns/10ps
module tb_top
  import cam_pkg::*;
;
  logic core_clk, rst_b, reg_wr, reg_rd, first_cascade_enable, second_cascade_enable;
  logic fast_flag_clear, normal_mode_indicator, cascade_event, underflow_irq;
  logic first_overflow_flag, second_overflow_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] edge_rise_en, edge_fall_en, capture_pin, capture_flags, channel_share;
  logic [15:0] timer_count;
  int n_fail = 0;
  int checks = 0;
  int n_cap, n_share, n_ovf;

  always #2.5 core_clk = ~core_clk;

  pin_source pins_u (.core_clk(core_clk), .capture_pin(capture_pin),
    .cascade_event(cascade_event));
  capture_accumulator_modulus_unit dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .capture_pin(capture_pin), .edge_rise_en(edge_rise_en),
    .edge_fall_en(edge_fall_en), .timer_count(timer_count),
    .first_cascade_enable(first_cascade_enable), .second_cascade_enable(second_cascade_enable),
    .first_cascade_event(cascade_event), .fast_flag_clear(fast_flag_clear),
    .normal_mode_indicator(normal_mode_indicator), .capture_flags(capture_flags),
    .channel_share(channel_share), .first_overflow_flag(first_overflow_flag),
    .second_overflow_flag(second_overflow_flag), .underflow_irq(underflow_irq));

  always @(posedge core_clk) begin
    if (capture_flags[0] === 1'b1) n_cap++;
    if (channel_share[0] === 1'b1) n_share++;
    if (first_overflow_flag === 1'b1) n_ovf++;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask

  task automatic edge0(input logic lvl, input logic [15:0] t);
    @(posedge core_clk);
    timer_count <= t;
    pins_u.set_pin(0, lvl);
    cyc(3);
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (underflow_irq !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk("underflow raised", underflow_irq, 1'b1);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    wr(ADDR_SYS, 8'h12);
    wr(ADDR_SYS, 8'h34);
    rd(ADDR_SYS, d);
    chk("system control once", d, 8'h12);
    @(posedge core_clk);
    normal_mode_indicator <= 1'b0;
    wr(ADDR_SYS, 8'h00);
    rd(ADDR_SYS, d);
    chk("system control special", d, 8'h00);
    wr(ADDR_DLY, 8'hFF);
    rd(ADDR_DLY, d);
    chk("delay select", d, 8'h03);
    wr(ADDR_DLY, 8'h00);
    wr(ADDR_MC_CTL, 8'h18);
    rd(ADDR_MC_CTL, d);
    chk("force bits read zero", d, 8'h00);
    rd(8'hF0, d);
    chk("unmapped read", d, 8'h00);
    rd(ADDR_MC_HI, d);
    chk("idle count high", d, 8'hFF);
  endtask

  task automatic t_cascade();
    logic [7:0] d;
    @(posedge core_clk);
    first_cascade_enable <= 1'b1;
    wr(ADDR_ACC3, 8'hFF);
    wr(ADDR_ACC2, 8'hFE);
    n_ovf = 0;
    pins_u.count_pulse();
    pins_u.count_pulse();
    cyc(3);
    chk("first overflow count", n_ovf, 1);
    rd(ADDR_ACC3, d);
    chk("cascade high", d, 8'h00);
    rd(ADDR_ACC2, d);
    chk("cascade low", d, 8'h00);
    @(posedge core_clk);
    first_cascade_enable <= 1'b0;
  endtask

  task automatic t_down();
    int n;
    logic [15:0] v;
    wr(ADDR_MC_CTL, 8'h85);
    wr(ADDR_MC_HI, 8'h00);
    wr(ADDR_MC_LO, 8'h05);
    wait_irq(60, n);
    chk("divide by four span", n >= 18 && n <= 26, 1'b1);
    cyc(20);
    rd16(ADDR_MC_HI, v);
    chk("one-shot stops", v, 16'h0000);
    wr(ADDR_MC_FLG, 8'h00);
    cyc(3);
    chk("flag kept on zero write", underflow_irq, 1'b1);
    wr(ADDR_MC_FLG, 8'h80);
    cyc(3);
    chk("flag cleared", underflow_irq, 1'b0);
    wr(ADDR_MC_HI, 8'h00);
    wr(ADDR_MC_LO, 8'h02);
    wait_irq(30, n);
    @(posedge core_clk);
    fast_flag_clear <= 1'b1;
    rd(ADDR_MC_HI, v[7:0]);
    cyc(3);
    chk("fast clear", underflow_irq, 1'b0);
    @(posedge core_clk);
    fast_flag_clear <= 1'b0;
    // Reload mode is changed only while disabled, so no stale zero reloads at once.
    wr(ADDR_MC_CTL, 8'h00);
    wr(ADDR_MC_CTL, 8'hC4);
    wr(ADDR_MC_HI, 8'h00);
    wr(ADDR_MC_LO, 8'h06);
    wr(ADDR_MC_CTL, 8'hCC);
    wait_irq(20, n);
    chk("force load span", n <= 10, 1'b1);
    wr(ADDR_MC_FLG, 8'h80);
    cyc(2);
    wait_irq(20, n);
    wr(ADDR_MC_CTL, 8'hE4);
    rd16(ADDR_MC_HI, v);
    chk("load register read", v, 16'h0006);
    wr(ADDR_MC_CTL, 8'h00);
  endtask

  task automatic t_capture();
    logic [15:0] v;
    wr(ADDR_SYS, 8'h10);
    n_cap = 0;
    n_share = 0;
    edge0(1'b1, 16'h1111);
    rd16(ADDR_CAP, v);
    chk("capture value", v, 16'h1111);
    edge0(1'b0, 16'h2222);
    edge0(1'b1, 16'h3333);
    wr(ADDR_MC_FLG, 8'h0F);
    rd(ADDR_MC_FLG, v[7:0]);
    chk("first edge falling", v[0], 1'b0);
    chk("flag per edge", n_cap, 3);
    chk("shared pulses", n_share, 3);
    wr(ADDR_NOVW, 8'h01);
    edge0(1'b0, 16'h4444);
    rd16(ADDR_CAP, v);
    chk("full capture kept", v, 16'h3333);
    edge0(1'b1, 16'h5555);
    rd16(ADDR_CAP, v);
    chk("empty capture taken", v, 16'h5555);
  endtask

  task automatic t_queue();
    logic [15:0] v;
    wr(ADDR_SYS, 8'h0A);
    rd16(ADDR_CAP_HOLD, v);
    n_cap = 0;
    edge0(1'b0, 16'h6666);
    chk("no flag before move", n_cap, 0);
    edge0(1'b1, 16'h7777);
    chk("flag on move", n_cap, 1);
    rd16(ADDR_CAP_HOLD, v);
    chk("queued holding", v, 16'h6666);
    rd16(ADDR_CAP, v);
    chk("queued capture", v, 16'h7777);
    wr(ADDR_NOVW, 8'h00);
  endtask

  task automatic t_latch();
    logic [15:0] v;
    wr(ADDR_SYS, 8'h03);
    wr(ADDR_ACC_EN, 8'h01);
    edge0(1'b0, 16'h8888);
    edge0(1'b1, 16'h9999);
    wr(ADDR_MC_CTL, 8'h10);
    rd16(ADDR_CAP_HOLD, v);
    chk("forced latch capture", v, 16'h9999);
    rd(ADDR_ACC_HOLD, v[7:0]);
    chk("forced latch count", v[7:0], 8'h02);
    rd(ADDR_ACC0, v[7:0]);
    chk("count cleared", v[7:0], 8'h00);
    wr(ADDR_MC_CTL, 8'h04);
    edge0(1'b0, 16'hAAAA);
    wr(ADDR_MC_HI, 8'h00);
    wr(ADDR_MC_LO, 8'h00);
    rd16(ADDR_CAP_HOLD, v);
    chk("zero write latch", v, 16'hAAAA);
    wr(ADDR_MC_CTL, 8'h00);
  endtask

  task automatic t_delay();
    wr(ADDR_SYS, 8'h00);
    wr(ADDR_DLY, 8'h01);
    n_cap = 0;
    pins_u.set_pin(0, 1'b1);
    cyc(250);
    chk("no pulse before delay", n_cap, 0);
    cyc(12);
    chk("pulse after delay", n_cap, 1);
    pins_u.set_pin(0, 1'b0);
    cyc(5);
    pins_u.set_pin(0, 1'b1);
    cyc(300);
    chk("narrow pulse dropped", n_cap, 1);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, first_cascade_enable, second_cascade_enable, fast_flag_clear} = 5'h00;
    normal_mode_indicator = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    edge_rise_en = 4'hF;
    edge_fall_en = 4'hF;
    timer_count = 16'h0000;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_cascade();
    t_down();
    t_capture();
    t_queue();
    t_latch();
    t_delay();
    give_verdict();
  end
endmodule

bind capture_accumulator_modulus_unit cam_checker chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .capture_pin(capture_pin), .edge_rise_en(edge_rise_en),
  .edge_fall_en(edge_fall_en), .timer_count(timer_count),
  .first_cascade_enable(first_cascade_enable), .second_cascade_enable(second_cascade_enable),
  .first_cascade_event(first_cascade_event), .fast_flag_clear(fast_flag_clear),
  .normal_mode_indicator(normal_mode_indicator), .capture_flags(capture_flags),
  .channel_share(channel_share), .first_overflow_flag(first_overflow_flag),
  .second_overflow_flag(second_overflow_flag), .underflow_irq(underflow_irq));
